// >>> core/async_serial_transceiver.sv
// full-duplex async serial transceiver with apb registers and fifos
`timescale 1ns/10ps
// Notes on behaviour
// - enabled module owns both serial pins
// - idle enabled transmitter drives line high
// - reset leaves module off, pins returned
// - disable empties fifos, resets baud counter
// - disable clears error/tx flags, sets idle
// - disable keeps configuration and divisor
// - disable aborts frames; re-enable starts from idle
// - format field and stop count select
// - default framing eight, none, one
// - written word queues in tx fifo; shifter loads when idle, tx enabled, no break
// - four-deep nine-bit tx fifo, full flag
// - write to full tx fifo dropped
// - reset empties both fifos
// - tx irq per transfer or on empty
// - break forces zero, no tx irq
// - rx read pops, updates error flags
// - four-deep rx fifo, avail flag, stale read
// - rx irq threshold one, three, four
// - overrun when full at stop, hold
// - framing error on zero stop, buffered
// - parity error buffered with word
module async_serial_transceiver
	import uart_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        serial_in,
	output logic             serial_out,
	output logic             serial_out_oe_n,
	output logic             tx_irq,
	output logic             rx_irq
);
	////////////////////////////////////////////////////////////////////////
	st_t           s;        // current state
	st_t           n;        // next state
	logic          acc;      // apb access phase
	logic          done;     // apb transfer completes
	logic [PW-1:0] tcnt;     // tx fifo fill
	logic [PW-1:0] rcnt;     // rx fifo fill
	logic          tick;     // sixteenth-bit tick
	logic          nine;     // nine-bit frames
	logic          paron;    // parity enabled
	logic          rxin;     // synchronised line
	logic [PW-1:0] rnew;     // rx fill after push
	logic [8:0]    rword;    // received data word

	// register index decode, shared by read and write paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	assign acc   = psel & penable;
	assign done  = acc & s.pready;
	assign tcnt  = s.twp - s.trp;
	assign rcnt  = s.rwp - s.rrp;
	assign tick  = s.on & (s.bcnt == 16'h0000);
	assign nine  = (s.fmt == FMT_9N);
	assign paron = (s.fmt == FMT_8E) | (s.fmt == FMT_8O);
	assign rxin  = s.sync2;
	assign rnew  = rcnt + 3'(1);
	assign rword = nine ? s.rsh : {1'b0, s.rsh[8:1]};

	assign prdata          = s.prdata;
	assign pready          = s.pready;
	assign pslverr         = s.pslverr;
	assign serial_out      = s.out;
	assign serial_out_oe_n = s.oe_n;
	assign tx_irq          = s.txirq;
	assign rx_irq          = s.rxirq;

	////////////////////////////////////////////////////////////////////////
	// next-state logic for bus, baud, transmitter and receiver
	always_comb begin
		n = s;
		n.txirq = 1'b0;
		n.rxirq = 1'b0;
		n.sync1 = serial_in;
		n.sync2 = s.sync1;
		// apb: one wait state, then complete
		n.pready  = acc & ~s.pready;
		n.pslverr = 1'b0;
		if (acc & ~s.pready) begin
			n.prdata = 32'h0000_0000;
			if (hit(paddr, OFS_MODE)) begin
				n.prdata[B_ON]   = s.on;
				n.prdata[2:1]    = s.fmt;
				n.prdata[B_STOP] = s.stop2;
			end else if (hit(paddr, OFS_STAT)) begin
				n.prdata[B_TXISEL]  = s.txisel;
				n.prdata[B_BRK]     = s.brk;
				n.prdata[B_TXEN]    = s.txen;
				n.prdata[B_FULL]    = (tcnt == PW'(DEPTH));
				n.prdata[B_SHEMPTY] = (s.tst == T_IDLE);
				n.prdata[7:6]       = s.rxthr;
				n.prdata[B_ADDR_DETECT_ENABLE]   = s.addr_detect_enable;
				n.prdata[B_RX_IDLE_FLAG]   = (s.rst == R_IDLE) | (s.rst == R_WAIT);
				n.prdata[B_PARITY_FLAG]    = (rcnt != 0) & s.rxf[s.rrp[1:0]][9];
				n.prdata[B_FRAMING_FLAG]    = (rcnt != 0) & s.rxf[s.rrp[1:0]][10];
				n.prdata[B_OVERRUN_FLAG]    = s.overrun_flag;
				n.prdata[B_AVAIL]   = (rcnt != 0);
			end else if (hit(paddr, OFS_RX)) begin
				// empty fifo returns the stale word
				n.prdata[8:0] = (rcnt != 0) ? s.rxf[s.rrp[1:0]][8:0]
					: s.rhold;
			end else if (hit(paddr, OFS_BAUD)) begin
				n.prdata[15:0] = s.baud;
			end else if (!hit(paddr, OFS_TX)) begin
				n.pslverr = 1'b1;
			end
		end
		// register writes take effect at completion
		if (done & pwrite) begin
			if (hit(paddr, OFS_MODE)) begin
				n.on    = pwdata[B_ON];
				n.fmt   = pwdata[2:1];
				n.stop2 = pwdata[B_STOP];
			end
			if (hit(paddr, OFS_STAT)) begin
				n.txisel = pwdata[B_TXISEL];
				n.brk    = pwdata[B_BRK];
				n.txen   = pwdata[B_TXEN];
				n.rxthr  = pwdata[7:6];
				n.addr_detect_enable  = pwdata[B_ADDR_DETECT_ENABLE];
				// software may only clear overrun
				if (!pwdata[B_OVERRUN_FLAG])
					n.overrun_flag = 1'b0;
			end
			if (hit(paddr, OFS_BAUD))
				n.baud = pwdata[15:0];
			// full fifo drops the word untouched
			if (hit(paddr, OFS_TX) && s.on && tcnt != PW'(DEPTH)) begin
				n.txf[s.twp[1:0]] = pwdata[8:0];
				n.twp = s.twp + 3'(1);
			end
		end
		// reading the port pops the head word
		if (done & ~pwrite & hit(paddr, OFS_RX) & (rcnt != 0)) begin
			n.rrp   = s.rrp + 3'(1);
			n.rhold = s.rxf[s.rrp[1:0]][8:0];
		end
		// baud counter: tick every divisor+1 clocks
		n.bcnt = tick ? s.baud : s.bcnt - 16'h0001;
		// transmitter
		case (s.tst)
			T_IDLE: begin
				// break holds words back, so it raises no irq
				if (s.txen && !s.brk && tcnt != 0) begin
					n.tsh   = s.txf[s.trp[1:0]];
					n.trp   = s.trp + 3'(1);
					n.tst   = T_START;
					n.tsub  = 4'h0;
					n.tbit  = 4'h0;
					n.tpar  = 1'b0;
					n.txirq = ~s.txisel | (tcnt == 3'(1));
				end
			end
			T_START: begin
				if (tick) begin
					n.tsub = s.tsub + 4'h1;
					if (s.tsub == SUB_LAST)
						n.tst = T_DATA;
				end
			end
			T_DATA: begin
				if (tick) begin
					n.tsub = s.tsub + 4'h1;
					if (s.tsub == SUB_LAST) begin
						n.tsh  = {1'b0, s.tsh[8:1]};
						n.tpar = s.tpar ^ s.tsh[0];
						n.tbit = s.tbit + 4'h1;
						if (s.tbit == (nine ? 4'h8 : 4'h7)) begin
							n.tbit = 4'h0;
							n.tst  = paron ? T_PAR : T_STOP;
						end
					end
				end
			end
			T_PAR: begin
				if (tick) begin
					n.tsub = s.tsub + 4'h1;
					if (s.tsub == SUB_LAST)
						n.tst = T_STOP;
				end
			end
			T_STOP: begin
				if (tick) begin
					n.tsub = s.tsub + 4'h1;
					if (s.tsub == SUB_LAST) begin
						if (s.stop2 && s.tbit == 4'h0)
							n.tbit = 4'h1;
						else
							n.tst = T_IDLE;
					end
				end
			end
			default: n.tst = T_IDLE;
		endcase
		// line level from current state, break wins
		case (s.tst)
			T_START: n.out = 1'b0;
			T_DATA:  n.out = s.tsh[0];
			T_PAR:   n.out = s.tpar ^ (s.fmt == FMT_8O);
			default: n.out = 1'b1;
		endcase
		if (s.brk)
			n.out = 1'b0;
		// receiver
		case (s.rst)
			R_IDLE: begin
				// overrun stops new frames until cleared
				if (!s.overrun_flag && !rxin) begin
					n.rst  = R_START;
					n.rsub = 4'h0;
				end
			end
			R_START: begin
				if (tick) begin
					n.rsub = s.rsub + 4'h1;
					if (s.rsub == SUB_MID) begin
						n.rsub  = 4'h0;
						n.rbit  = 4'h0;
						n.rpar  = 1'b0;
						n.rperr = 1'b0;
						n.rferr = 1'b0;
						n.rst   = rxin ? R_IDLE : R_DATA;
					end
				end
			end
			R_DATA: begin
				if (tick) begin
					n.rsub = s.rsub + 4'h1;
					if (s.rsub == SUB_LAST) begin
						n.rsh  = {rxin, s.rsh[8:1]};
						n.rpar = s.rpar ^ rxin;
						n.rbit = s.rbit + 4'h1;
						if (s.rbit == (nine ? 4'h8 : 4'h7)) begin
							n.rbit = 4'h0;
							n.rst  = paron ? R_PAR : R_STOP;
						end
					end
				end
			end
			R_PAR: begin
				if (tick) begin
					n.rsub = s.rsub + 4'h1;
					if (s.rsub == SUB_LAST) begin
						n.rperr = s.rpar ^ rxin ^ (s.fmt == FMT_8O);
						n.rst   = R_STOP;
					end
				end
			end
			R_STOP: begin
				if (tick) begin
					n.rsub = s.rsub + 4'h1;
					if (s.rsub == SUB_LAST) begin
						n.rferr = s.rferr | ~rxin;
						if (s.stop2 && s.rbit == 4'h0) begin
							n.rbit = 4'h1;
						end else if (rcnt == PW'(DEPTH)) begin
							n.overrun_flag = 1'b1;
							n.rst  = R_IDLE;
						end else begin
							n.rxf[s.rwp[1:0]] = {n.rferr, s.rperr, rword};
							n.rwp   = s.rwp + 3'(1);
							n.rxirq = ~s.rxthr[1]
								| (s.rxthr[0] ? rnew == 3'(4)
								: rnew == 3'(3));
							// a break must end before a new start
							n.rst   = rxin ? R_IDLE : R_WAIT;
						end
					end
				end
			end
			R_WAIT: begin
				if (rxin)
					n.rst = R_IDLE;
			end
			default: n.rst = R_IDLE;
		endcase
		// pins follow the module-enable bit
		n.oe_n = ~n.on;
		// disable: flush, abort, clear flags; config kept
		if (!s.on) begin
			n.twp   = '0;
			n.trp   = '0;
			n.rwp   = '0;
			n.rrp   = '0;
			n.bcnt  = 16'h0000;
			n.tst   = T_IDLE;
			n.rst   = R_IDLE;
			n.txen  = 1'b0;
			n.brk   = 1'b0;
			n.overrun_flag  = 1'b0;
			n.out   = 1'b1;
			n.txirq = 1'b0;
			n.rxirq = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register; reset gives module off, 8n1, empty fifos
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s       <= '0;
			s.on    <= 1'b0;
			s.fmt   <= FMT_8N;
			s.tst   <= T_IDLE;
			s.rst   <= R_IDLE;
			s.sync1 <= 1'b1;
			s.sync2 <= 1'b1;
			s.out   <= 1'b1;
			s.oe_n  <= 1'b1;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_break;
		s.brk && s.on |=> !serial_out;
	endproperty
	a_break: assert property (p_break)
		else $error("break not driving zero");

	property p_idle_high;
		s.on && !s.brk && s.tst == T_IDLE |=> serial_out;
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("idle line not high");

	property p_pins;
		s.on |=> serial_out_oe_n == !$past(n.on);
	endproperty
	a_pins: assert property (p_pins)
		else $error("pin ownership wrong");

	property p_off;
		!s.on |=> tcnt == 0 && rcnt == 0 && !s.overrun_flag && !s.txen
			&& s.tst == T_IDLE && s.rst == R_IDLE
			&& serial_out_oe_n == !s.on;
	endproperty
	a_off: assert property (p_off)
		else $error("disable did not reset state");

	property p_full_drop;
		done && pwrite && paddr == OFS_TX && tcnt == PW'(DEPTH)
			|=> $stable(s.twp) && $stable(s.txf);
	endproperty
	a_full_drop: assert property (p_full_drop)
		else $error("write into full fifo accepted");

	property p_tx_irq;
		tx_irq |-> $past(s.tst) == T_IDLE && s.tst == T_START
			&& ($past(!s.txisel) || $past(tcnt) == 3'(1));
	endproperty
	a_tx_irq: assert property (p_tx_irq)
		else $error("tx irq without qualifying transfer");

	property p_rx_irq;
		rx_irq |-> rcnt == $past(rcnt) + 3'(1) - (s.rrp - $past(s.rrp))
			&& ($past(!s.rxthr[1]) || rcnt != 0);
	endproperty
	a_rx_irq: assert property (p_rx_irq)
		else $error("rx irq without push");

	property p_overrun;
		s.rst == R_STOP && tick && s.rsub == SUB_LAST && rcnt == PW'(DEPTH)
			&& !(s.stop2 && s.rbit == 4'h0) && s.on |=> s.overrun_flag ##1 s.overrun_flag;
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not flagged");

	property p_pop;
		done && !pwrite && paddr == OFS_RX && rcnt != 0 && s.on
			|=> s.rrp == $past(s.rrp) + 3'(1);
	endproperty
	a_pop: assert property (p_pop)
		else $error("read did not pop");

	property p_bus;
		acc && !pready |=> pready ##1 !pready;
	endproperty
	a_bus: assert property (p_bus)
		else $error("apb answer timing wrong");
endmodule : async_serial_transceiver

// >>> include/uart_pkg.sv
// shared constants, types and state layout of the serial transceiver
package uart_pkg;
	localparam int      DEPTH      = 4;       // words per fifo
	localparam int      PW         = 3;       // fifo pointer width
	localparam int      TXW        = 9;       // transmit word width
	localparam int      RXW        = 11;      // data plus both error bits
	localparam logic [7:0] OFS_MODE = 8'h00;  // mode_reg
	localparam logic [7:0] OFS_STAT = 8'h04;  // status_ctrl_reg
	localparam logic [7:0] OFS_TX   = 8'h08;  // tx_write_port
	localparam logic [7:0] OFS_RX   = 8'h0c;  // rx_read_port
	localparam logic [7:0] OFS_BAUD = 8'h10;  // baud_divisor
	localparam int      B_ON       = 15;      // mode: module_on
	localparam int      B_STOP     = 0;       // mode: stop_count_select
	localparam int      B_TXISEL   = 15;      // status fields
	localparam int      B_BRK      = 11;
	localparam int      B_TXEN     = 10;
	localparam int      B_FULL     = 9;
	localparam int      B_SHEMPTY  = 8;
	localparam int      B_ADDR_DETECT_ENABLE    = 5;
	localparam int      B_RX_IDLE_FLAG    = 4;
	localparam int      B_PARITY_FLAG     = 3;
	localparam int      B_FRAMING_FLAG     = 2;
	localparam int      B_OVERRUN_FLAG     = 1;
	localparam int      B_AVAIL    = 0;
	localparam logic [1:0] FMT_8N   = 2'b00;  // format_select codes
	localparam logic [1:0] FMT_8E   = 2'b01;
	localparam logic [1:0] FMT_8O   = 2'b10;
	localparam logic [1:0] FMT_9N   = 2'b11;
	localparam logic [3:0] SUB_LAST = 4'hf;   // last tick of a bit
	localparam logic [3:0] SUB_MID  = 4'h7;   // start bit midpoint
	typedef enum logic [4:0] {
		T_IDLE = 5'b0_0001, T_START = 5'b0_0010, T_DATA = 5'b0_0100,
		T_PAR  = 5'b0_1000, T_STOP  = 5'b1_0000
	} tx_state_t;
	typedef enum logic [5:0] {
		R_IDLE = 6'b00_0001, R_START = 6'b00_0010, R_DATA = 6'b00_0100,
		R_PAR  = 6'b00_1000, R_STOP  = 6'b01_0000, R_WAIT = 6'b10_0000
	} rx_state_t;
	typedef struct packed {
		logic                      on;       // module_on
		logic [1:0]                fmt;      // format_select
		logic                      stop2;    // stop_count_select
		logic                      txisel;   // tx_irq_select
		logic                      brk;      // tx_break_force
		logic                      txen;     // tx_enable
		logic [1:0]                rxthr;    // rx_irq_threshold
		logic                      addr_detect_enable;    // addr_detect_enable
		logic                      overrun_flag;     // overrun_flag
		logic [15:0]               baud;     // baud_divisor
		logic [15:0]               bcnt;     // baud counter
		logic [DEPTH-1:0][TXW-1:0] txf;      // transmit fifo
		logic [PW-1:0]             twp;
		logic [PW-1:0]             trp;
		logic [8:0]                tsh;      // tx_shift_reg
		tx_state_t                 tst;
		logic [3:0]                tsub;
		logic [3:0]                tbit;
		logic                      tpar;
		logic [DEPTH-1:0][RXW-1:0] rxf;      // receive fifo
		logic [PW-1:0]             rwp;
		logic [PW-1:0]             rrp;
		logic [8:0]                rsh;      // rx_shift_reg
		rx_state_t                 rst;
		logic [3:0]                rsub;
		logic [3:0]                rbit;
		logic                      rpar;
		logic                      rperr;
		logic                      rferr;
		logic [8:0]                rhold;    // last word read
		logic                      sync1;
		logic                      sync2;
		logic                      out;
		logic                      oe_n;
		logic                      txirq;
		logic                      rxirq;
		logic [31:0]               prdata;
		logic                      pready;
		logic                      pslverr;
	} st_t;
endpackage : uart_pkg

// >>> tb/serial_peer.sv
// remote serial device model driving the transceiver's line input
`timescale 1ns/10ps
module serial_peer #(
	parameter int BIT = 16 // clocks per bit at divisor zero
) (
	input  wire logic pclk,
	output logic      line
);
	// idle mark level until a frame is sent
	initial line = 1'b1;

	// n bits lsb first, then one idle bit time
	task automatic send(input logic [12:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			line <= b[i];
			repeat (BIT) @(posedge pclk);
		end
		line <= 1'b1;
		repeat (BIT) @(posedge pclk);
	endtask : send
endmodule : serial_peer

// >>> tb/tb.sv
// self-checking testbench of the serial transceiver
`timescale 1ns/10ps
module tb;
	import uart_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        serial_in;
	logic        serial_out;
	logic        oe_n;
	logic        tx_irq;
	logic        rx_irq;
	int          n_fail;
	int          n_tests;
	int          ntx;       // tx irq pulses
	int          nrx;       // rx irq pulses
	logic        err;       // last slave error
	logic [15:0] q;         // last read data
	logic [12:0] f;         // expected frame
	logic [12:0] g;         // captured frame

	async_serial_transceiver u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe_n(oe_n),
		.tx_irq(tx_irq), .rx_irq(rx_irq)
	);
	serial_peer u_peer (.pclk(pclk), .line(serial_in));

	// 10 MHz clock
	always #50 pclk = ~pclk;
	// count interrupt pulses
	always @(posedge pclk) begin
		if (tx_irq === 1'b1) ntx++;
		if (rx_irq === 1'b1) nrx++;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [15:0] s, e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [15:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
		if (k == 20) begin
			n_fail++;
			close_out();
		end
		q = prdata[15:0];
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// expected frame bits for a format, returns bit count
	function automatic int mk(input logic [1:0] fm, input logic s2,
			input logic [8:0] d, output logic [12:0] b);
		int n;
		b = '1;
		b[0] = 1'b0;
		n = (fm == FMT_9N) ? 10 : 9;
		for (int i = 1; i < n; i++) b[i] = d[i-1];
		if (fm == FMT_8E || fm == FMT_8O) begin
			b[n] = ^d[7:0] ^ (fm == FMT_8O);
			n++;
		end
		return n + 1 + int'(s2);
	endfunction : mk

	// capture n bits at bit centres, returns at last centre
	task automatic grab(input int n, output logic [12:0] b);
		int k;
		b = '1;
		for (k = 0; k < 3000 && serial_out !== 1'b0; k++) @(posedge pclk);
		if (k == 3000) begin
			n_fail++;
			close_out();
		end
		repeat (8) @(posedge pclk);
		for (int i = 0; i < n; i++) begin
			b[i] = serial_out;
			if (i < n - 1) repeat (16) @(posedge pclk);
		end
	endtask : grab

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("line", 16'(serial_out), 16'h0001);
		chk("oe_n", 16'(oe_n), 16'h0001);
		apb(1'b0, OFS_MODE, 16'h0000);
		chk("mode", q, 16'h0000);
		apb(1'b0, OFS_STAT, 16'h0000);
		chk("status", q, 16'h0110);
		apb(1'b0, 8'h14, 16'h0000);
		chk("slverr", 16'(err), 16'h0001);
		$display("test reset done");
	endtask : t_reset

	task automatic t_tx();
		int n;
		logic [8:0] d;
		apb(1'b1, OFS_BAUD, 16'h0000);
		for (int fm = 0; fm < 4; fm++) begin
			d = (fm == 3) ? 9'h1a5 : 9'h0a5;
			apb(1'b1, OFS_MODE, {1'b1, 12'h000, 2'(fm), 1'(fm)});
			apb(1'b1, OFS_STAT, 16'h0400);
			ntx = 0;
			apb(1'b1, OFS_TX, 16'(d));
			n = mk(2'(fm), 1'(fm), d, f);
			grab(n, g);
			chk("frame", 16'(g), 16'(f));
			chk("oe_n", 16'(oe_n), 16'h0000);
			repeat (40) @(posedge pclk);
			chk("idle", 16'(serial_out), 16'h0001);
			chk("txirq", 16'(ntx), 16'h0001);
		end
		$display("test tx done");
	endtask : t_tx

	task automatic t_fifo();
		apb(1'b1, OFS_MODE, 16'h8000);
		apb(1'b1, OFS_STAT, 16'h8000);
		for (int i = 0; i < 5; i++) apb(1'b1, OFS_TX, 16'(i + 1));
		apb(1'b0, OFS_STAT, 16'h0000);
		chk("full", q & 16'h0200, 16'h0200);
		ntx = 0;
		apb(1'b1, OFS_STAT, 16'h8400);
		for (int i = 0; i < 4; i++) begin
			void'(mk(FMT_8N, 1'b0, 9'(i + 1), f));
			grab(10, g);
			chk("fifo", 16'(g), 16'(f));
		end
		// a fifth frame would be in its start bit here
		repeat (16) @(posedge pclk);
		chk("drop", 16'(serial_out), 16'h0001);
		chk("txirq", 16'(ntx), 16'h0001);
		$display("test fifo done");
	endtask : t_fifo

	task automatic t_brk();
		ntx = 0;
		apb(1'b1, OFS_STAT, 16'h0c00);
		repeat (13 * 16) @(posedge pclk);
		chk("break", 16'(serial_out), 16'h0000);
		apb(1'b1, OFS_STAT, 16'h0400);
		repeat (32) @(posedge pclk);
		chk("stop", 16'(serial_out), 16'h0001);
		chk("txirq", 16'(ntx), 16'h0000);
		$display("test break done");
	endtask : t_brk

	task automatic t_rx();
		apb(1'b1, OFS_MODE, 16'h8002);
		apb(1'b1, OFS_STAT, 16'h0080);
		nrx = 0;
		void'(mk(FMT_8E, 1'b0, 9'h03c, f));
		u_peer.send(f, 11);
		u_peer.send(f ^ 13'h0200, 11);
		u_peer.send(f & 13'h1bff, 11);
		repeat (40) @(posedge pclk);
		chk("rxirq", 16'(nrx), 16'h0001);
		apb(1'b0, OFS_STAT, 16'h0000);
		chk("head", q & 16'h000f, 16'h0001);
		apb(1'b0, OFS_RX, 16'h0000);
		chk("rx", q, 16'h003c);
		apb(1'b0, OFS_STAT, 16'h0000);
		chk("parity_flag", q & 16'h000f, 16'h0009);
		apb(1'b0, OFS_RX, 16'h0000);
		apb(1'b0, OFS_STAT, 16'h0000);
		chk("framing_flag", q & 16'h000f, 16'h0005);
		apb(1'b0, OFS_RX, 16'h0000);
		apb(1'b0, OFS_STAT, 16'h0000);
		chk("empty", q & 16'h000f, 16'h0000);
		apb(1'b0, OFS_RX, 16'h0000);
		chk("stale", q, 16'h003c);
		$display("test rx done");
	endtask : t_rx

	task automatic t_ovr();
		apb(1'b1, OFS_MODE, 16'h8000);
		apb(1'b1, OFS_STAT, 16'h00c0);
		nrx = 0;
		for (int i = 0; i < 5; i++) begin
			void'(mk(FMT_8N, 1'b0, 9'(16 + i), f));
			u_peer.send(f, 10);
		end
		repeat (40) @(posedge pclk);
		chk("rxirq", 16'(nrx), 16'h0001);
		apb(1'b0, OFS_STAT, 16'h0000);
		chk("ovr", q & 16'h0003, 16'h0003);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, OFS_RX, 16'h0000);
			chk("held", q, 16'(16 + i));
		end
		apb(1'b1, OFS_STAT, 16'h00c0);
		apb(1'b0, OFS_STAT, 16'h0000);
		chk("ovrclr", q & 16'h0003, 16'h0000);
		// nine-bit reception, irq on every push
		apb(1'b1, OFS_MODE, 16'h8006);
		apb(1'b1, OFS_STAT, 16'h0000);
		nrx = 0;
		void'(mk(FMT_9N, 1'b0, 9'h155, f));
		u_peer.send(f, 11);
		repeat (40) @(posedge pclk);
		chk("rxirq9", 16'(nrx), 16'h0001);
		apb(1'b0, OFS_RX, 16'h0000);
		chk("rx9", q, 16'h0155);
		$display("test overrun done");
	endtask : t_ovr

	task automatic t_off();
		apb(1'b1, OFS_MODE, 16'h8005);
		apb(1'b1, OFS_STAT, 16'h80e0);
		apb(1'b1, OFS_TX, 16'h0011);
		void'(mk(FMT_8O, 1'b1, 9'h011, f));
		u_peer.send(f, 12);
		apb(1'b0, OFS_STAT, 16'h0000);
		chk("avail", q & 16'h0001, 16'h0001);
		apb(1'b1, OFS_BAUD, 16'h0003);
		apb(1'b1, OFS_MODE, 16'h0005);
		repeat (4) @(posedge pclk);
		apb(1'b0, OFS_MODE, 16'h0000);
		chk("mode", q, 16'h0005);
		apb(1'b0, OFS_BAUD, 16'h0000);
		chk("baud", q, 16'h0003);
		apb(1'b0, OFS_STAT, 16'h0000);
		chk("status", q, 16'h81f0);
		chk("oe_n", 16'(oe_n), 16'h0001);
		apb(1'b1, OFS_MODE, 16'h8005);
		apb(1'b0, OFS_STAT, 16'h0000);
		chk("flush", q, 16'h81f0);
		apb(1'b1, OFS_STAT, 16'h84e0);
		repeat (40) @(posedge pclk);
		chk("txflush", 16'(serial_out), 16'h0001);
		$display("test disable done");
	endtask : t_off

	////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_tx();
		t_fifo();
		t_brk();
		t_rx();
		t_ovr();
		t_off();
		close_out();
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge pclk);
		n_fail++;
		close_out();
	end
endmodule : tb
